// ### hdl/scsi_crc_parity_error_control.v
/*
 * SCSI parity/CRC/AIP error control: checking enables, interval CRC
 * requests in target DT data phases, CRC protocol check, halt and
 * interrupt policy, master data parity interrupt masking.
 * Assumes all inputs but nrst synchronous to ref_clk, a simple strobe register
 * port, and that the bus engine reports phases and byte transfers.
 */
`timescale 1ns/1ps
`include "scsi_err_regs.vh"

module scsi_crc_parity_error_control (
   input  wire        ref_clk,
   input  wire        nrst,
   input  wire        clk_en,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   input  wire        target_mode,
   input  wire        dt_data_phase,
   input  wire        cmd_stat_msg_phase,
   input  wire        phase_change,
   input  wire        byte_xfer,
   input  wire [7:0]  rx_data,
   input  wire        rx_parity,
   input  wire        rx_aip_ok,
   input  wire        crc_error,
   input  wire        crc_req_sent,
   input  wire        transfer_end,
   input  wire        master_parity_err,
   output reg         crc_req,
   output reg         aip_gen_enable,
   output reg         scsi_atn,
   output reg         halt,
   output reg         interrupt_pin_a,
   output reg         irq
);

   reg        rst_s1_reg;
   reg        rst_n_reg;
   reg  [7:0] scsi_control_zero_reg;
   reg  [7:0] scsi_control_one_reg;
   reg  [7:0] scsi_control_four_reg;
   reg  [7:0] crc_control_zero_reg;
   reg  [7:0] scsi_irq_enable_one_reg;
   reg        scsi_irq_status_zero_reg;
   reg  [7:0] dma_irq_enable_reg;
   reg        dma_status_reg;
   reg  [`EV_WIDTH-1:0] ev_status_reg;
   reg  [`EV_WIDTH-1:0] ev_enable_reg;
   reg  [16:0] crc_cnt_reg;
   reg        crc_pend_reg;
   reg        data_since_req_reg;
   reg        halt_pending_reg;

   wire [3:0] code = crc_control_zero_reg[`CRC_INTERVAL_MSB:0];
   wire [16:0] interval;
   wire       parity_err;
   wire       aip_err;
   wire       crc_err_q;
   wire       gross_err;
   wire       scsi_err;
   wire       interval_hit;
   wire       wr_hit_clear;
   wire       counted_byte;
   wire       rd_irq_status;
   wire       rd_dma_status;
   wire       wr_irq_status;
   wire       wr_crc_control;
   reg  [7:0] rdata_next;

   ////////////////////////////////////////////////////////////////////////
   // interval decode; reserved codes return zero so requests stay off

   function [16:0] crc_interval;
      input [3:0] c;
      begin
         if (c == 4'h0 || c > `CRC_CODE_MAX)
            crc_interval = 17'h00000;
         else
            // five-bit sum: code ten needs a shift of sixteen
            crc_interval = 17'h00001 << ({1'b0, c} + 5'h06);
      end
   endfunction

   // strobe and offset match, shared by every side-effect decode
   function addr_hit;
      input       strobe;
      input [7:0] addr;
      input [7:0] offset;
      begin
         addr_hit = strobe && (addr == offset);
      end
   endfunction

   assign interval = crc_interval(code);

   assign parity_err = scsi_control_zero_reg[`B_ERROR_CHECK_ENABLE] & byte_xfer &
                       ~(^{rx_data, rx_parity});
   assign aip_err = scsi_control_four_reg[`B_AIP_ENABLE] & cmd_stat_msg_phase & byte_xfer & ~rx_aip_ok;
   assign crc_err_q = crc_error & ~crc_control_zero_reg[`B_CRC_CHECK_DISABLE];
   assign gross_err = phase_change & dt_data_phase & data_since_req_reg &
                      ~crc_control_zero_reg[`B_CRC_PROTO_DISABLE];
   assign scsi_err = parity_err | aip_err | crc_err_q;
   assign counted_byte = target_mode & dt_data_phase & byte_xfer;
   // compared one ahead so the request leaves right after the last byte of the interval
   assign interval_hit = counted_byte & (interval != 17'h00000) & (crc_cnt_reg + 17'h00001 >= interval);

   ////////////////////////////////////////////////////////////////////////
   // strobe decode

   assign wr_hit_clear   = addr_hit(reg_wr, reg_addr, `OFF_EVT_CLEAR);
   assign rd_irq_status  = addr_hit(reg_rd, reg_addr, `OFF_SCSI_IRQ_STATUS_ZERO);
   assign rd_dma_status  = addr_hit(reg_rd, reg_addr, `OFF_DMA_STATUS);
   assign wr_irq_status  = addr_hit(reg_wr, reg_addr, `OFF_SCSI_IRQ_STATUS_ZERO);
   assign wr_crc_control = addr_hit(reg_wr, reg_addr, `OFF_CRC_CONTROL_ZERO);

   ////////////////////////////////////////////////////////////////////////
   // reset release

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg  <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg  <= rst_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers and self-clearing counter reset

   always @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         scsi_control_zero_reg    <= `RST_BYTE;
         scsi_control_one_reg     <= `RST_BYTE;
         scsi_control_four_reg    <= `RST_BYTE;
         crc_control_zero_reg     <= `RST_BYTE;
         scsi_irq_enable_one_reg  <= `RST_BYTE;
         dma_irq_enable_reg       <= `RST_BYTE;
         ev_enable_reg            <= 4'h0;
      end else if (clk_en) begin
         // register writes
         if (reg_wr) begin
            if (reg_addr == `OFF_SCSI_CONTROL_ZERO)
               scsi_control_zero_reg <= reg_wdata;
            else if (reg_addr == `OFF_SCSI_CONTROL_ONE)
               scsi_control_one_reg <= reg_wdata;
            else if (reg_addr == `OFF_SCSI_CONTROL_FOUR)
               scsi_control_four_reg <= reg_wdata;
            else if (reg_addr == `OFF_CRC_CONTROL_ZERO)
               crc_control_zero_reg <= reg_wdata;
            else if (reg_addr == `OFF_SCSI_IRQ_ENABLE_ONE)
               scsi_irq_enable_one_reg <= reg_wdata;
            else if (reg_addr == `OFF_DMA_IRQ_ENABLE)
               dma_irq_enable_reg <= reg_wdata;
            else if (reg_addr == `OFF_EVT_ENABLE)
               ev_enable_reg <= reg_wdata[`EV_WIDTH-1:0];
         end
         // self-clearing reset bit
         // a fresh write of the bit wins, so it always stands for one cycle
         if (crc_control_zero_reg[`B_CRC_COUNTER_RESET] && !wr_crc_control)
            crc_control_zero_reg[`B_CRC_COUNTER_RESET] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // crc protocol state: pending flag and data since the last request

   always @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         crc_pend_reg       <= 1'b1;
         data_since_req_reg <= 1'b0;
      end else if (clk_en) begin
         // pending flag
         // a byte beside the sent request counts as data since, so the flag stays
         if (byte_xfer)
            data_since_req_reg <= 1'b1;
         else if (crc_req_sent)
            data_since_req_reg <= 1'b0;
         if (byte_xfer)
            crc_pend_reg <= 1'b1;
         else if (crc_req_sent)
            crc_pend_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // error response: attention and halt

   always @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         halt_pending_reg <= 1'b0;
         scsi_atn         <= 1'b0;
         halt             <= 1'b0;
      end else if (clk_en) begin
         if (scsi_err & ~target_mode & scsi_control_zero_reg[`B_ATTENTION_ON_ERROR])
            scsi_atn <= 1'b1;
         else if (phase_change)
            scsi_atn <= 1'b0;

         if (scsi_err | gross_err) begin
            if (target_mode & scsi_control_one_reg[`B_HALT_ON_ERROR_DISABLE] & ~transfer_end)
               halt_pending_reg <= 1'b1;
            else
               halt <= 1'b1;
         end else if (halt_pending_reg & transfer_end) begin
            halt_pending_reg <= 1'b0;
            halt <= 1'b1;
         end else if (wr_irq_status) begin
            halt <= 1'b0;
         end

      end
   end

   ////////////////////////////////////////////////////////////////////////
   // crc interval counter

   always @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         crc_cnt_reg <= 17'h00000;
         crc_req     <= 1'b0;
      end else if (clk_en) begin
         // counter clear
         // seventeen bits so the 65536-byte interval compares without wrapping
         if (crc_control_zero_reg[`B_CRC_COUNTER_RESET])
            crc_cnt_reg <= 17'h00000;
         else if (interval_hit)
            crc_cnt_reg <= 17'h00000;
         else if (counted_byte)
            crc_cnt_reg <= crc_cnt_reg + 17'h00001;
         crc_req <= interval_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky status flags; a new event beats a clear in the same cycle

   always @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         scsi_irq_status_zero_reg <= 1'b0;
         dma_status_reg           <= 1'b0;
         ev_status_reg            <= 4'h0;
      end else if (clk_en) begin
         if (scsi_err)
            scsi_irq_status_zero_reg <= 1'b1;
         else if (rd_irq_status)
            scsi_irq_status_zero_reg <= 1'b0;
         if (master_parity_err)
            dma_status_reg <= 1'b1;
         else if (rd_dma_status)
            dma_status_reg <= 1'b0;
         // event order: deferred halt, master parity, gross error, scsi error
         ev_status_reg <= (ev_status_reg & ~(wr_hit_clear ? reg_wdata[`EV_WIDTH-1:0] : 4'h0)) |
                          {halt_pending_reg & transfer_end, master_parity_err, gross_err, scsi_err};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read multiplexer; unmapped offsets read as zero

   always @* begin
      rdata_next = 8'h00;
      if (reg_rd) begin
         if (reg_addr == `OFF_SCSI_CONTROL_ZERO)
            rdata_next = {scsi_control_zero_reg[7:3], crc_pend_reg, scsi_control_zero_reg[1:0]};
         else if (reg_addr == `OFF_SCSI_CONTROL_ONE)
            rdata_next = scsi_control_one_reg;
         else if (reg_addr == `OFF_SCSI_CONTROL_FOUR)
            rdata_next = scsi_control_four_reg;
         else if (reg_addr == `OFF_CRC_CONTROL_ZERO)
            rdata_next = crc_control_zero_reg;
         else if (reg_addr == `OFF_SCSI_IRQ_ENABLE_ONE)
            rdata_next = scsi_irq_enable_one_reg;
         else if (reg_addr == `OFF_SCSI_IRQ_STATUS_ZERO)
            rdata_next = {7'h00, scsi_irq_status_zero_reg};
         else if (reg_addr == `OFF_DMA_IRQ_ENABLE)
            rdata_next = dma_irq_enable_reg;
         else if (reg_addr == `OFF_DMA_STATUS)
            rdata_next = {1'b0, dma_status_reg, 6'h00};
         else if (reg_addr == `OFF_EVT_STATUS)
            rdata_next = {4'h0, ev_status_reg};
         else if (reg_addr == `OFF_EVT_ENABLE)
            rdata_next = {4'h0, ev_enable_reg};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs; the pins lag their status flags by one cycle

   always @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         reg_rdata       <= 8'h00;
         aip_gen_enable  <= 1'b0;
         interrupt_pin_a <= 1'b0;
         irq             <= 1'b0;
      end else if (clk_en) begin
         aip_gen_enable  <= scsi_control_four_reg[`B_AIP_ENABLE] & cmd_stat_msg_phase;
         interrupt_pin_a <= (scsi_irq_status_zero_reg & scsi_irq_enable_one_reg[`B_PARITY_IRQ]) |
                            (dma_status_reg & dma_irq_enable_reg[`B_MASTER_PARITY]);
         irq             <= |(ev_status_reg & ev_enable_reg);
         // read data stands for one cycle only
         reg_rdata       <= rdata_next;
      end
   end

endmodule

// ### hdl/scsi_err_regs.vh
/*
 * Register offsets, field positions and reset values for the SCSI
 * parity/CRC/AIP error-control block.
 * Assumes inclusion by the block's design file only; definitions only.
 */
`ifndef SCSI_ERR_REGS_VH
`define SCSI_ERR_REGS_VH

// register offsets (8-bit address)
`define OFF_SCSI_CONTROL_ZERO    8'h00
`define OFF_SCSI_CONTROL_ONE     8'h01
`define OFF_SCSI_CONTROL_FOUR    8'h02
`define OFF_CRC_CONTROL_ZERO     8'h03
`define OFF_SCSI_IRQ_ENABLE_ONE  8'h04
`define OFF_SCSI_IRQ_STATUS_ZERO 8'h05
`define OFF_DMA_IRQ_ENABLE       8'h06
`define OFF_DMA_STATUS           8'h07
`define OFF_EVT_STATUS           8'h08
`define OFF_EVT_ENABLE           8'h09
`define OFF_EVT_CLEAR            8'h0A

// scsi_control_zero fields
`define B_ERROR_CHECK_ENABLE     3
`define B_CRC_REQ_PENDING        2
`define B_ATTENTION_ON_ERROR     1
// scsi_control_one fields
`define B_HALT_ON_ERROR_DISABLE  5
// scsi_control_four fields
`define B_AIP_ENABLE             6
// crc_control_zero fields
`define B_CRC_CHECK_DISABLE      7
`define B_CRC_PROTO_DISABLE      6
`define B_CRC_COUNTER_RESET      5
`define CRC_INTERVAL_MSB         3
// scsi_irq_enable_one / scsi_irq_status_zero fields
`define B_PARITY_IRQ             0
// dma enable / status fields
`define B_MASTER_PARITY          6
// event status fields
`define B_EV_SCSI_ERR            0
`define B_EV_GROSS_ERR           1
`define B_EV_MASTER_PARITY       2
`define B_EV_HALT                3

// interval codes
`define CRC_CODE_MAX             4'hA
`define CRC_BASE_SHIFT           7

`define RST_BYTE                 8'h00
`define EV_WIDTH                 4

`endif

// ### verification/scsi_err_asserts.sv
/* checker of the error-control block's port timing.
   assumes a bind onto the block top and a single clock. */
`timescale 1ns/1ps
module scsi_err_asserts (
   input wire       ref_clk,
   input wire       nrst,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire       target_mode,
   input wire       dt_data_phase,
   input wire       phase_change,
   input wire       byte_xfer,
   input wire       crc_error,
   input wire       transfer_end,
   input wire       master_parity_err,
   input wire       crc_req,
   input wire       scsi_atn,
   input wire       halt,
   input wire       interrupt_pin_a,
   input wire       irq
);
wire cause = byte_xfer | crc_error | transfer_end | phase_change;
wire src   = byte_xfer | crc_error | master_parity_err | reg_wr;
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!nrst);
sequence s_quiet; (!crc_req && !halt && !irq && !interrupt_pin_a) [*2]; endsequence
sequence s_crc_gap; (!crc_req) [*8]; endsequence
a_reset_quiet: assert property ($rose(nrst) |-> s_quiet) else $error("output active after reset");
a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
a_crc_spacing: assert property (crc_req |=> s_crc_gap) else $error("crc requests too close");
a_crc_target: assert property (crc_req |-> $past(target_mode) && $past(dt_data_phase))
   else $error("crc request outside target dt");
a_atn_initiator: assert property ($rose(scsi_atn) |-> !$past(target_mode))
   else $error("attention raised as target");
a_halt_cause: assert property ($rose(halt) |-> $past(cause)) else $error("halt without cause");
a_pin_cause: assert property ($rose(interrupt_pin_a) |-> $past(src) || $past(src, 2))
   else $error("interrupt pin without cause");
a_atn_drop: assert property (phase_change && !byte_xfer && !crc_error |=> !scsi_atn)
   else $error("attention held over phase change");
endmodule
////////////////////////////////////////
bind scsi_crc_parity_error_control scsi_err_asserts chk (.ref_clk, .nrst, .reg_wr, .reg_rd, .reg_rdata,
   .target_mode, .dt_data_phase, .phase_change, .byte_xfer, .crc_error, .transfer_end,
   .master_parity_err, .crc_req, .scsi_atn, .halt, .interrupt_pin_a, .irq);

// ### verification/scsi_peer_model.sv
/* bus peer: hands one received byte a cycle while run is high and
   confirms each crc request a cycle later; assumes ref_clk only. */
`timescale 1ns/1ps
module scsi_peer_model (
   input  wire       ref_clk,
   input  wire       run,
   input  wire       bad,
   input  wire [7:0] tx_byte,
   input  wire       crc_req,
   output reg        byte_xfer = 1'b0,
   output reg  [7:0] rx_data = 8'h00,
   output reg        rx_parity = 1'b0,
   output reg        rx_aip_ok = 1'b1,
   output reg        crc_req_sent = 1'b0
);
always @(posedge ref_clk) begin
   byte_xfer <= run;
   // odd parity unless told to corrupt
   rx_parity <= run ? ~^tx_byte ^ bad : ~rx_parity;
   // idle lines toggle so a stale byte never looks valid
   rx_data <= run ? tx_byte : ~rx_data;
   rx_aip_ok <= !bad;
   crc_req_sent <= crc_req;
end
endmodule

// ### verification/scsi_crc_parity_error_control_tb.sv
/* testbench: register traffic, peer bytes and error pulses into the block.
   assumes peer model and checker compiled first. */
`timescale 1ns/1ps
`define CHK(g,e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected t=%0t got %h want %h", $time, g, e); end end
module scsi_crc_parity_error_control_tb;
reg         ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0, bad = 1'b0;
reg         target_mode = 1'b0, dt_data_phase = 1'b0, cmd_stat_msg_phase = 1'b0;
reg         phase_change = 1'b0, transfer_end = 1'b0, master_parity_err = 1'b0, crc_error = 1'b0;
reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, tx_byte = 8'h00, d;
reg  [3:0]  c;
reg  [31:0] lfsr = 32'h50D6;
wire [7:0]  reg_rdata, rx_data;
wire        byte_xfer, rx_parity, rx_aip_ok, crc_req_sent, crc_req, aip_gen_enable, scsi_atn, halt;
wire        interrupt_pin_a, irq;
integer     num_errors = 0, compares = 0, cyc = 0, e, n;
scsi_crc_parity_error_control dut (.ref_clk, .nrst, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .target_mode, .dt_data_phase, .cmd_stat_msg_phase, .phase_change, .byte_xfer,
   .rx_data, .rx_parity, .rx_aip_ok, .crc_error, .crc_req_sent, .transfer_end, .master_parity_err,
   .crc_req, .aip_gen_enable, .scsi_atn, .halt, .interrupt_pin_a, .irq);
scsi_peer_model peer (.ref_clk, .run, .bad, .tx_byte, .crc_req, .byte_xfer, .rx_data, .rx_parity,
   .rx_aip_ok, .crc_req_sent);
initial forever #20 ref_clk = ~ref_clk;
always @(posedge ref_clk) begin
   cyc = cyc + 1;
   if (cyc == 20000) begin
      num_errors++;
      conclude;
   end
end
function [31:0] nx(input [31:0] v);
   nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
// requests in 256 bytes: none as initiator, none for codes 0 and 11-15
function integer ncrc(input [3:0] k, input t);
   ncrc = (t && k >= 4'h1 && k <= 4'hA) ? 256 / (128 << (k - 1)) : 0;
endfunction
task wt(input integer k); repeat (k) @(posedge ref_clk); #1; endtask
task wr(input [7:0] a, input [7:0] v);
   @(posedge ref_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v; end
   @(posedge ref_clk) reg_wr <= 1'b0;
endtask
task rd(input [7:0] a);
   @(posedge ref_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
   @(posedge ref_clk) reg_rd <= 1'b0;
   #1 d = reg_rdata;
endtask
task send(input integer cnt, input b);
   repeat (cnt) @(posedge ref_clk) begin lfsr = nx(lfsr); run <= 1'b1; bad <= b; tx_byte <= lfsr[7:0]; end
   @(posedge ref_clk) begin run <= 1'b0; bad <= 1'b0; end
endtask
task conclude;
   $display("mismatches %0d of %0d comparisons", num_errors, compares);
   if (num_errors == 0 && compares > 0)
      $display("Result: passed");
   else
      $display("Result: failed");
   $finish;
endtask
initial begin
   repeat (8) @(posedge ref_clk);
   nrst <= 1'b1;
   wt(3);
   rd(8'h00); `CHK(d, 8'h04)
   wr(8'h0B, 8'hFF);
   rd(8'h0B); `CHK(d, 8'h00)
   // initiator parity error with error checking on and the attention, interrupt and scsi error event enables off, then on
   for (e = 0; e < 2; e++) begin
      wr(8'h00, e ? 8'h0A : 8'h08);
      wr(8'h04, e ? 8'h01 : 8'h00);
      wr(8'h06, e ? 8'h40 : 8'h00);
      wr(8'h09, e ? 8'h01 : 8'h00);
      send(1, 1'b1);
      master_parity_err <= 1'b1;
      @(posedge ref_clk) master_parity_err <= 1'b0;
      wt(3);
      `CHK(halt, 1'b1)
      `CHK(scsi_atn, e[0])
      `CHK(interrupt_pin_a, e[0])
      `CHK(irq, e[0])
      rd(8'h05); `CHK(d, 8'h01)
      rd(8'h07); `CHK(d, 8'h40)
      wr(8'h05, 8'h00);
      wr(8'h0A, 8'h0F);
      phase_change <= 1'b1;
      @(posedge ref_clk) phase_change <= 1'b0;
      wt(3);
      `CHK({interrupt_pin_a, irq, halt, scsi_atn}, 4'h0)
   end
   // target with halt disabled waits for the transfer end
   @(posedge ref_clk) target_mode <= 1'b1;
   wr(8'h01, 8'h20);
   send(1, 1'b1);
   wt(4); `CHK(halt, 1'b0)
   @(posedge ref_clk) transfer_end <= 1'b1;
   @(posedge ref_clk) transfer_end <= 1'b0;
   wt(2); `CHK(halt, 1'b1)
   rd(8'h05);
   wr(8'h05, 8'h00);
   wr(8'h00, 8'h00);
   wr(8'h0A, 8'h0F);
   cmd_stat_msg_phase <= 1'b1;
   wr(8'h02, 8'h40); wt(2); `CHK(aip_gen_enable, 1'b1)
   wr(8'h02, 8'h00); wt(2); `CHK(aip_gen_enable, 1'b0)
   @(posedge ref_clk) begin cmd_stat_msg_phase <= 1'b0; dt_data_phase <= 1'b1; end
   // codes 0, 1, 2, reserved 11, then code 1 as initiator
   for (e = 0; e < 5; e++) begin
      c = (e == 3) ? 4'hB : (e == 4) ? 4'h1 : e[3:0];
      @(posedge ref_clk) target_mode <= (e != 4);
      wr(8'h03, {4'h2, c});
      rd(8'h03); `CHK(d, {4'h0, c})
      n = 0;
      fork
         send(256, 1'b0);
         repeat (262) @(negedge ref_clk) n = n + crc_req;
      join
      `CHK(n, ncrc(c, e != 4))
      rd(8'h00); `CHK(d[2], ncrc(c, e != 4) == 0)
   end
   // initiator in dt: phase change with data since the last request, protocol check on then off
   for (e = 0; e < 2; e++) begin
      wr(8'h03, e ? 8'h41 : 8'h01);
      wr(8'h0A, 8'h0F);
      send(1, 1'b0);
      @(posedge ref_clk) phase_change <= 1'b1;
      @(posedge ref_clk) phase_change <= 1'b0;
      wt(2);
      `CHK(halt, !e[0])
      rd(8'h08); `CHK(d[1], !e[0])
      wr(8'h05, 8'h00);
   end
   // crc error reported only while crc checking is on
   for (e = 0; e < 2; e++) begin
      wr(8'h03, e ? 8'h80 : 8'h00);
      @(posedge ref_clk) crc_error <= 1'b1;
      @(posedge ref_clk) crc_error <= 1'b0;
      wt(2);
      rd(8'h05); `CHK(d, {7'h00, !e[0]})
      wr(8'h05, 8'h00);
   end
   conclude;
end
endmodule
